// >>> src/pbc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PBC_MAP_SVH
`define PBC_MAP_SVH
`define PBC_ADDR_BCTL        5'h00
`define PBC_ADDR_BSTAT       5'h01
`define PBC_ADDR_FUNC_CTL    5'h1C
`define PBC_ADDR_VENDOR_LO   5'h10
`define PBC_ADDR_VENDOR_HI   5'h1F
`define PBC_BIT_RESET        15
`define PBC_BIT_LOOPBACK     14
`define PBC_BIT_SPEED        13
`define PBC_BIT_ANEG_EN      12
`define PBC_BIT_PWRDN        11
`define PBC_BIT_ISOLATE      10
`define PBC_BIT_ANEG_RST     9
`define PBC_BIT_DUPLEX       8
`define PBC_BIT_COL_TEST     7
`define PBC_BIT_FC_LOOPBACK  0
`define PBC_BCTL_WR_MASK     16'h7D80
`define PBC_BSTAT_VALUE      16'h7809
`define PBC_FUNC_CTL_RESET   16'h0000
`define PBC_FUNC_CTL_MASK    16'h0001
`define PBC_STAT_ANEG_DONE   5
`define PBC_STAT_LINK        2
`define PBC_MDIO_TA_BITS     6'd14
`define PBC_SOFT_RST_CYCLES  4'd8
`endif

// >>> src/pbc_pkg.sv
// types for the management register bank
package pbc_pkg;
    typedef enum logic [2:0] {
        PBC_IDLE   = 3'b000,
        PBC_HEADER = 3'b001,
        PBC_TURN   = 3'b010,
        PBC_WDATA  = 3'b011,
        PBC_RDATA  = 3'b100
    } pbc_state_t;
    typedef logic [15:0] pbc_word_t;
endpackage

// >>> src/pbc_mdio_slave.sv
// clause-22 frame engine on mdc/mdio
`timescale 1ns/1ps
`include "pbc_map.svh"
module pbc_mdio_slave
    import pbc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      mdc,
    input  wire logic      mdio_in,
    output logic           mdio_out,
    output logic           mdio_oe,
    input  wire logic [4:0] phy_addr,
    output logic           wr_strobe,
    output logic           rd_strobe,
    output logic [4:0]     reg_addr,
    output pbc_word_t      wr_data,
    input  wire pbc_word_t rd_data
);
    pbc_state_t  state;
    logic        mdc_q;
    logic        rise;
    logic        fall;
    logic [5:0]  cnt;
    logic [5:0]  pre_ones;
    logic [13:0] hdr;
    logic [15:0] shift;
    logic        is_read;
    logic        mine;

    assign rise = mdc & ~mdc_q;
    assign fall = ~mdc & mdc_q;

    always_ff @(posedge clk) begin
        if (!rst_b) mdc_q <= 1'b0;
        else mdc_q <= mdc;
    end

    // frame sequencing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state     <= PBC_IDLE;
            cnt       <= 6'd0;
            pre_ones  <= 6'd0;
            hdr       <= 14'h0000;
            shift     <= 16'h0000;
            is_read   <= 1'b0;
            mine      <= 1'b0;
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
            reg_addr  <= 5'h00;
            wr_data   <= 16'h0000;
        end else begin
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
            case (state)
                PBC_IDLE: begin
                    if (rise) begin
                        if (mdio_in) begin
                            pre_ones <= (pre_ones == 6'd63) ? pre_ones : pre_ones + 6'd1;
                        end else begin
                            // start bit 0 after ones; second start bit next
                            if (pre_ones != 6'd0) begin
                                state <= PBC_HEADER;
                                cnt   <= 6'd1;
                                hdr   <= 14'h0000;
                            end
                            pre_ones <= 6'd0;
                        end
                    end
                end
                PBC_HEADER: begin
                    if (rise) begin
                        hdr <= {hdr[12:0], mdio_in};
                        cnt <= cnt + 6'd1;
                        if (cnt == `PBC_MDIO_TA_BITS - 6'd1) begin
                            // hdr[11:0]: st1 op2 phy5 reg4, this bit is reg lsb
                            is_read  <= hdr[10:9] == 2'b10;
                            mine     <= (hdr[11] == 1'b1) && (hdr[8:4] == phy_addr) &&
                                        (hdr[10:9] == 2'b10 || hdr[10:9] == 2'b01);
                            reg_addr <= {hdr[3:0], mdio_in};
                            state    <= PBC_TURN;
                            cnt      <= 6'd0;
                        end
                    end
                end
                PBC_TURN: begin
                    if (rise) begin
                        cnt <= cnt + 6'd1;
                        if (cnt == 6'd0 && is_read && mine) begin
                            rd_strobe <= 1'b1;
                        end
                        if (cnt == 6'd1) begin
                            cnt   <= 6'd0;
                            shift <= rd_data;
                            state <= is_read ? PBC_RDATA : PBC_WDATA;
                        end
                    end
                end
                PBC_WDATA: begin
                    if (rise) begin
                        shift <= {shift[14:0], mdio_in};
                        cnt   <= cnt + 6'd1;
                        if (cnt == 6'd15) begin
                            wr_data   <= {shift[14:0], mdio_in};
                            wr_strobe <= mine;
                            state     <= PBC_IDLE;
                        end
                    end
                end
                PBC_RDATA: begin
                    if (rise) begin
                        cnt <= cnt + 6'd1;
                        if (cnt == 6'd15) state <= PBC_IDLE;
                    end
                    if (fall && cnt != 6'd0) shift <= {shift[14:0], 1'b0};
                end
                default: state <= PBC_IDLE;
            endcase
        end
    end

    // read data driven on falling edge, sampled by the station on rising
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mdio_out <= 1'b1;
            mdio_oe  <= 1'b0;
        end else if (state == PBC_TURN && mine && is_read && cnt == 6'd1 && fall) begin
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b1;
        end else if (state == PBC_RDATA && mine && fall) begin
            mdio_out <= (cnt == 6'd0) ? rd_data[15] : shift[14];
            mdio_oe  <= 1'b1;
        end else if (state == PBC_IDLE && fall) begin
            mdio_out <= 1'b1;
            mdio_oe  <= 1'b0;
        end
    end
endmodule

// >>> src/pbc_regs.sv
// management register bank: basic control and status
`timescale 1ns/1ps
`include "pbc_map.svh"
// Overview of operation
// - thirty-two directly addressed registers over mdio
// - low sixteen standard, 10h-1Fh vendor
// - reset bit resets device, self-clears
// - loopback returns rmii transmit to receive
// - loopback needs both control bits set
// - speed bit ignored while negotiation enabled
// - negotiation result overrides; enable reset from strap
// - power-down bit; full reset from power-down needs two resets
// - first reset clears power-down, second resets
// - isolate disconnects device from rmii
// - restart bit restarts negotiation, self-clears
// - power-down keeps only management alive
module pbc_regs
    import pbc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic [4:0] phy_addr,
    input  wire logic       negotiation_strap_pin,
    input  wire logic       aneg_done,
    input  wire logic       aneg_speed_100,
    input  wire logic       aneg_full_duplex,
    input  wire logic       link_up,
    output logic            core_reset,
    output logic            aneg_restart,
    output logic            aneg_enable,
    output logic            speed_100,
    output logic            full_duplex,
    output logic            loopback_active,
    output logic            line_disconnect,
    output logic            rmii_isolate,
    output logic            power_down,
    output logic            collision_test
);
    logic       wr_strobe;
    logic       rd_strobe;
    logic [4:0] reg_addr;
    pbc_word_t  wr_data;
    pbc_word_t  rd_data;
    pbc_word_t  func_ctl;
    logic       lb_bit;
    logic       speed_bit;
    logic       aneg_bit;
    logic       pd_bit;
    logic       iso_bit;
    logic       duplex_bit;
    logic       col_bit;
    logic       relatch;
    logic [3:0] rst_cnt;
    logic       bctl_wr;
    logic       soft_rst_req;
    logic       pd_exit_only;

    function automatic logic is_vendor(input logic [4:0] a);
        is_vendor = (a >= `PBC_ADDR_VENDOR_LO) && (a <= `PBC_ADDR_VENDOR_HI);
    endfunction

    pbc_mdio_slave u_mdio (
        .clk       (clk),
        .rst_b     (rst_b),
        .mdc       (mdc),
        .mdio_in   (mdio_in),
        .mdio_out  (mdio_out),
        .mdio_oe   (mdio_oe),
        .phy_addr  (phy_addr),
        .wr_strobe (wr_strobe),
        .rd_strobe (rd_strobe),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data),
        .rd_data   (rd_data)
    );

    assign bctl_wr      = wr_strobe && reg_addr == `PBC_ADDR_BCTL;
    assign soft_rst_req = bctl_wr && wr_data[`PBC_BIT_RESET];
    // in power-down a reset write only clears power-down
    assign pd_exit_only = soft_rst_req && pd_bit;

    // soft reset pulse stretch; reset bit reads zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rst_cnt <= 4'd0;
        end else if (soft_rst_req && !pd_exit_only) begin
            rst_cnt <= `PBC_SOFT_RST_CYCLES;
        end else if (rst_cnt != 4'd0) begin
            rst_cnt <= rst_cnt - 4'd1;
        end
    end
    assign core_reset = (rst_cnt != 4'd0) || !rst_b;

    // strap latch at hardware reset release and at each full soft reset
    always_ff @(posedge clk) begin
        if (!rst_b) relatch <= 1'b1;
        else relatch <= soft_rst_req && !pd_exit_only;
    end

    // basic control fields
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lb_bit     <= 1'b0;
            speed_bit  <= 1'b1;
            pd_bit     <= 1'b0;
            iso_bit    <= 1'b0;
            duplex_bit <= 1'b1;
            col_bit    <= 1'b0;
        end else if (pd_exit_only) begin
            pd_bit <= 1'b0;
        end else if (soft_rst_req) begin
            lb_bit     <= 1'b0;
            speed_bit  <= 1'b1;
            pd_bit     <= 1'b0;
            iso_bit    <= 1'b0;
            duplex_bit <= 1'b1;
            col_bit    <= 1'b0;
        end else if (bctl_wr) begin
            lb_bit     <= wr_data[`PBC_BIT_LOOPBACK];
            speed_bit  <= wr_data[`PBC_BIT_SPEED];
            pd_bit     <= wr_data[`PBC_BIT_PWRDN];
            iso_bit    <= wr_data[`PBC_BIT_ISOLATE];
            duplex_bit <= wr_data[`PBC_BIT_DUPLEX];
            col_bit    <= wr_data[`PBC_BIT_COL_TEST];
        end
    end

    // negotiation enable tracks strap at reset, then software
    always_ff @(posedge clk) begin
        if (!rst_b) aneg_bit <= 1'b0;
        else if (relatch) aneg_bit <= negotiation_strap_pin;
        else if (bctl_wr && !soft_rst_req) aneg_bit <= wr_data[`PBC_BIT_ANEG_EN];
    end

    // restart pulse; bit self-clears so always reads zero
    always_ff @(posedge clk) begin
        if (!rst_b) aneg_restart <= 1'b0;
        else aneg_restart <= bctl_wr && !soft_rst_req && wr_data[`PBC_BIT_ANEG_RST];
    end

    // function control holds loopback enable
    always_ff @(posedge clk) begin
        if (!rst_b || (soft_rst_req && !pd_exit_only)) func_ctl <= `PBC_FUNC_CTL_RESET;
        else if (wr_strobe && reg_addr == `PBC_ADDR_FUNC_CTL)
            func_ctl <= wr_data & `PBC_FUNC_CTL_MASK;
    end

    // effective controls
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aneg_enable     <= 1'b0;
            speed_100       <= 1'b1;
            full_duplex     <= 1'b1;
            loopback_active <= 1'b0;
            line_disconnect <= 1'b0;
            rmii_isolate    <= 1'b0;
            power_down      <= 1'b0;
            collision_test  <= 1'b0;
        end else begin
            aneg_enable     <= aneg_bit && !pd_bit;
            speed_100       <= aneg_bit ? aneg_speed_100 : speed_bit;
            full_duplex     <= aneg_bit ? aneg_full_duplex : duplex_bit;
            loopback_active <= lb_bit && func_ctl[`PBC_BIT_FC_LOOPBACK] && !pd_bit;
            line_disconnect <= lb_bit && func_ctl[`PBC_BIT_FC_LOOPBACK];
            rmii_isolate    <= iso_bit || pd_bit;
            power_down      <= pd_bit;
            collision_test  <= col_bit && !pd_bit;
        end
    end

    // read mux; reserved and unimplemented addresses return zero
    always_comb begin
        rd_data = 16'h0000;
        case (reg_addr)
            `PBC_ADDR_BCTL: begin
                rd_data[`PBC_BIT_LOOPBACK] = lb_bit;
                rd_data[`PBC_BIT_SPEED]    = speed_bit;
                rd_data[`PBC_BIT_ANEG_EN]  = aneg_bit;
                rd_data[`PBC_BIT_PWRDN]    = pd_bit;
                rd_data[`PBC_BIT_ISOLATE]  = iso_bit;
                rd_data[`PBC_BIT_DUPLEX]   = duplex_bit;
                rd_data[`PBC_BIT_COL_TEST] = col_bit;
            end
            `PBC_ADDR_BSTAT: begin
                rd_data = `PBC_BSTAT_VALUE;
                rd_data[`PBC_STAT_ANEG_DONE] = aneg_done && aneg_bit;
                rd_data[`PBC_STAT_LINK]      = link_up && !pd_bit;
            end
            `PBC_ADDR_FUNC_CTL: rd_data = func_ctl;
            default: rd_data = is_vendor(reg_addr) ? 16'h0000 : 16'h0000;
        endcase
    end
endmodule

// >>> dv/pbc_mgmt_master.sv
// station management master model for mdc/mdio frames
`timescale 1ns/1ps
module pbc_mgmt_master
    import pbc_pkg::*;
(
    input  wire logic clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    output logic      mdc,
    output logic      mdio_in,
    output logic      rd_done,
    output pbc_word_t rd_word
);
    logic drv_en = 1'b0;
    logic drv_val = 1'b1;
    initial begin
        mdc = 1'b0;
        rd_done = 1'b0;
        rd_word = 16'h0000;
    end
    // released line sits at the pull-up level
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
    task automatic bit_cyc(input logic en, input logic v, output logic s);
        mdc <= 1'b0;
        drv_en <= en;
        drv_val <= v;
        repeat (8) @(posedge clk);
        mdc <= 1'b1;
        repeat (8) @(posedge clk);
        s = mdio_in;
    endtask
    task automatic frame(input logic r, input logic [4:0] p, input logic [4:0] a,
                         input pbc_word_t d);
        logic [17:0] hdr;
        logic        s;
        pbc_word_t   q;
        hdr = {4'hf, 2'b01, r ? 2'b10 : 2'b01, p, a};
        for (int i = 17; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
        bit_cyc(!r, 1'b1, s);
        bit_cyc(!r, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(!r, d[i], s);
            q[i] = s;
        end
        // clock stands still between frames
        mdc <= 1'b0;
        drv_en <= 1'b0;
        rd_word <= q;
        rd_done <= r;
        @(posedge clk);
        rd_done <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// >>> dv/pbc_regs_asserts.sv
// assertions on the register bank ports
`timescale 1ns/1ps
module pbc_regs_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic aneg_done,
    input wire logic aneg_speed_100,
    input wire logic aneg_full_duplex,
    input wire logic core_reset,
    input wire logic aneg_restart,
    input wire logic aneg_enable,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic loopback_active,
    input wire logic line_disconnect,
    input wire logic rmii_isolate,
    input wire logic power_down,
    input wire logic collision_test
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_rs_pulse: assert property (aneg_restart |=> !aneg_restart)
        else $error("restart pulse too long");
    chk_rst_vals: assert property (disable iff (1'b0) !rst_b |=>
        speed_100 && full_duplex && !mdio_oe && !power_down && !rmii_isolate)
        else $error("bad reset levels");
    chk_rst_core: assert property (disable iff (1'b0) !rst_b |-> core_reset)
        else $error("core reset low during hardware reset");
    chk_an_ovr: assert property (aneg_enable && aneg_done && !core_reset &&
        $past(aneg_enable && aneg_done) |->
        speed_100 == $past(aneg_speed_100) && full_duplex == $past(aneg_full_duplex))
        else $error("negotiated result not applied");
    chk_soft_len: assert property ($rose(core_reset) |-> core_reset[*8] ##1 !core_reset)
        else $error("soft reset length wrong");
    chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround not driven low");
    chk_pd_exit: assert property ($fell(power_down) |-> !core_reset[*3])
        else $error("power-down exit reset the core");
    chk_soft_dflt: assert property ($fell(core_reset) |->
        !power_down && !rmii_isolate && !loopback_active && !collision_test)
        else $error("controls not defaulted");
    chk_loop_disc: assert property (loopback_active |-> line_disconnect)
        else $error("loopback with line connected");
    cover property (aneg_restart);
    cover property ($fell(power_down));
    cover property (loopback_active);
endmodule
bind pbc_regs pbc_regs_asserts pbc_regs_asserts_inst (.clk(clk), .rst_b(rst_b),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .aneg_done(aneg_done),
    .aneg_speed_100(aneg_speed_100), .aneg_full_duplex(aneg_full_duplex),
    .core_reset(core_reset), .aneg_restart(aneg_restart), .aneg_enable(aneg_enable),
    .speed_100(speed_100), .full_duplex(full_duplex), .loopback_active(loopback_active),
    .line_disconnect(line_disconnect), .rmii_isolate(rmii_isolate),
    .power_down(power_down), .collision_test(collision_test));

// >>> dv/pbc_regs_bench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module pbc_regs_bench;
    import pbc_pkg::*;
    localparam logic [4:0] PA = 5'h05;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b1;
    logic an_100 = 1'b1;
    logic an_fd = 1'b1;
    logic mdc, mdio_in, mdio_out, mdio_oe, rd_done, core_reset, aneg_restart, aneg_enable;
    logic speed_100, full_duplex, loopback_active, line_disconnect, rmii_isolate;
    logic power_down, collision_test;
    pbc_word_t rd_word, w;
    pbc_word_t exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int n_rst = 0;
    int n_rs = 0;
    int seed = 32'h0000_ff20;
    always #2.5 clk = ~clk;
    pbc_regs pbc_regs_inst (.clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(PA), .negotiation_strap_pin(strap),
        .aneg_done(1'b1), .aneg_speed_100(an_100), .aneg_full_duplex(an_fd), .link_up(1'b1),
        .core_reset(core_reset), .aneg_restart(aneg_restart), .aneg_enable(aneg_enable),
        .speed_100(speed_100), .full_duplex(full_duplex), .loopback_active(loopback_active),
        .line_disconnect(line_disconnect), .rmii_isolate(rmii_isolate),
        .power_down(power_down), .collision_test(collision_test));
    pbc_mgmt_master pbc_mgmt_master_inst (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_in(mdio_in), .rd_done(rd_done), .rd_word(rd_word));
    task automatic check(input string nm, input pbc_word_t e, input pbc_word_t s);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic lv(input logic [7:0] e);
        check("levels", {8'h00, e}, {8'h00, speed_100, full_duplex, aneg_enable, power_down,
            rmii_isolate, collision_test, loopback_active, line_disconnect});
    endtask
    task automatic xf(input logic r, input logic [4:0] a, input pbc_word_t d);
        if (r) exp_q.push_back(d);
        pbc_mgmt_master_inst.frame(r, PA, a, d);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // result watcher: oldest note against each finished read
    always @(posedge clk) begin
        if (rd_done) begin
            if (exp_q.size() == 0) check("read count", 16'h0000, 16'h0001);
            else check("read data", exp_q.pop_front(), rd_word);
        end
        if (core_reset && rst_b) n_rst++;
        if (aneg_restart) n_rs++;
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        lv(8'he0);
        xf(1'b1, 5'h00, 16'h3100);
        xf(1'b1, 5'h01, 16'h782d);
        xf(1'b0, 5'h01, 16'h0000);
        xf(1'b1, 5'h01, 16'h782d);
        xf(1'b0, 5'h00, 16'h1000);
        lv(8'he0);
        an_100 <= 1'b0;
        an_fd <= 1'b0;
        repeat (3) @(posedge clk);
        lv(8'h20);
        xf(1'b0, 5'h00, 16'h2100);
        lv(8'hc0);
        for (int i = 0; i < 4; i++) begin
            w = 16'($random(seed)) & 16'h75ff;
            xf(1'b0, 5'h00, w);
            xf(1'b1, 5'h00, w & 16'h7d80);
            lv({w[12] ? {an_100, an_fd} : {w[13], w[8]}, w[12], 1'b0, w[10], w[7], 2'b00});
        end
        xf(1'b0, 5'h00, 16'h4000);
        lv(8'h00);
        xf(1'b0, 5'h1c, 16'h0001);
        lv(8'h03);
        xf(1'b1, 5'h1c, 16'h0001);
        xf(1'b0, 5'h00, 16'h0000);
        xf(1'b0, 5'h0f, 16'hffff);
        xf(1'b1, 5'h0f, 16'h0000);
        xf(1'b1, 5'h12, 16'h0000);
        exp_q.push_back(16'hffff);
        pbc_mgmt_master_inst.frame(1'b1, 5'h06, 5'h00, 16'h0000);
        pbc_mgmt_master_inst.frame(1'b0, 5'h06, 5'h00, 16'h0800);
        xf(1'b0, 5'h00, 16'h0200);
        check("restart pulses", 16'h0001, 16'(n_rs));
        xf(1'b1, 5'h00, 16'h0000);
        xf(1'b0, 5'h00, 16'h0800);
        lv(8'h18);
        xf(1'b1, 5'h00, 16'h0800);
        xf(1'b1, 5'h01, 16'h7809);
        n_rst = 0;
        strap <= 1'b0;
        xf(1'b0, 5'h00, 16'h8000);
        lv(8'h00);
        check("reset cycles", 16'h0000, 16'(n_rst));
        xf(1'b0, 5'h00, 16'h8000);
        repeat (12) @(posedge clk);
        check("reset cycles", 16'h0008, 16'(n_rst));
        lv(8'hc0);
        xf(1'b1, 5'h00, 16'h2100);
        repeat (4) @(posedge clk);
        check("pending reads", 16'h0000, 16'(exp_q.size()));
        end_sim();
    end
endmodule
